// >>> verilog/dmc_defines.vh
// timing and width constants for the multiplexed-address dram controller
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH
`define DMC_CLK_NS 10
`define DMC_ADDR_W 16
`define DMC_MUX_W 8
`define DMC_REF_ROWS 128
`define DMC_REF_ROW_W 7
// strobe and write timings in ns
`define DMC_ROW_PRE_NS 140
`define DMC_ROW_PULSE_NS 200
`define DMC_ROW_HOLD_NS 30
`define DMC_COL_LEAD_NS 40
`define DMC_COL_PULSE_NS 110
`define DMC_ACCESS_NS 200
`define DMC_STORE_NS 60
`define DMC_PAUSE_NS 100000
`define DMC_REF_PERIOD_NS 2000000
`define DMC_REF_EACH_NS (`DMC_REF_PERIOD_NS / `DMC_REF_ROWS)
`define DMC_INIT_CYCLES 8
// derived cycle counts; minimums round up
`define DMC_CYC(ns) (((ns) + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_T_PRE `DMC_CYC(`DMC_ROW_PRE_NS)
`define DMC_T_RAS `DMC_CYC(`DMC_ROW_PULSE_NS)
`define DMC_T_RAH `DMC_CYC(`DMC_ROW_HOLD_NS)
`define DMC_T_RCD `DMC_CYC(`DMC_COL_LEAD_NS)
`define DMC_T_CAS `DMC_CYC(`DMC_COL_PULSE_NS)
`define DMC_T_ACC `DMC_CYC(`DMC_ACCESS_NS)
`define DMC_T_WP `DMC_CYC(`DMC_STORE_NS)
// refresh interval rounds down so 128 rows fit in the period
`define DMC_T_REF (`DMC_REF_EACH_NS / `DMC_CLK_NS)
`define DMC_T_PAUSE `DMC_CYC(`DMC_PAUSE_NS)
`endif

// >>> verilog/dmc_sync.v
// three-stage synchroniser for the data-out pin
`timescale 1ns/100ps
`default_nettype none
module dmc_sync (
  // clock and reset
  input wire mclk_in,
  input wire srst_in,
  // raw pin and filtered level
  input wire pin_in,
  output reg level_out
);
  reg s1;
  reg s2;
  reg s3;
  // first stage only feeds the second; change taken once stages two and three agree
  always @(posedge mclk_in) begin
    if (srst_in) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_out <= s3;
      end
    end
  end
endmodule // dmc_sync
`default_nettype wire

// >>> verilog/dmc_ctrl.v
// host-side controller that drives a 64k x 1 multiplexed-address dram
//==========================================================
`timescale 1ns/100ps
`default_nettype none
`include "dmc_defines.vh"
module dmc_ctrl #(
  parameter [23:0] PAUSE_CYCLES = `DMC_T_PAUSE,
  parameter [23:0] REF_CYCLES = `DMC_T_REF
) (
  // clock and reset
  input wire mclk_in,
  input wire srst_in,
  // user request port
  input wire req_valid_in,
  input wire req_write_in,
  input wire req_rmw_in,
  input wire [15:0] req_addr_in,
  input wire req_data_in,
  output reg req_ready_out,
  output reg rd_valid_out,
  output reg rd_data_out,
  output reg init_done_out,
  // dram pins
  output reg ras_n_out,
  output reg cas_n_out,
  output reg we_n_out,
  output reg [7:0] mux_addr_out,
  output reg din_out,
  input wire dout_in
);
  //==========================================================
  // states
  localparam [3:0] ST_PAUSE = 4'd0;
  localparam [3:0] ST_IDLE = 4'd1;
  localparam [3:0] ST_ROW = 4'd2;
  localparam [3:0] ST_COL = 4'd3;
  localparam [3:0] ST_ACC = 4'd4;
  localparam [3:0] ST_WR = 4'd5;
  localparam [3:0] ST_END = 4'd6;
  localparam [3:0] ST_PRE = 4'd7;
  localparam [3:0] ST_REF = 4'd8;
  // cycle counts held at the timer width; init cycle count at the init counter width
  localparam [23:0] T_PRE = `DMC_T_PRE;
  localparam [23:0] T_RAS = `DMC_T_RAS;
  localparam [23:0] T_RAH = `DMC_T_RAH;
  localparam [23:0] T_RCD = `DMC_T_RCD;
  localparam [23:0] T_ACC = `DMC_T_ACC;
  localparam [23:0] T_WP = `DMC_T_WP;
  localparam [3:0] INIT_N = `DMC_INIT_CYCLES;

  reg [3:0] state;
  reg [23:0] tmr;
  reg [23:0] ref_tmr;
  reg ref_due;
  reg [6:0] ref_row;
  reg [3:0] init_cnt;
  reg op_write;
  reg op_rmw;
  reg [15:0] op_addr;
  reg op_data;
  wire dout_sync;
  wire ref_pending;

  //==========================================================
  // data-out pin enters through the synchroniser
  dmc_sync u_sync (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .pin_in(dout_in),
    .level_out(dout_sync)
  );

  assign ref_pending = ref_due | ~init_done_out;

  // refresh interval timer; a new tick wins over the clear
  always @(posedge mclk_in) begin
    if (srst_in) begin
      ref_tmr <= 24'h00_0000;
      ref_due <= 1'b0;
    end else if (ref_tmr >= REF_CYCLES - 24'd1) begin
      ref_tmr <= 24'h00_0000;
      ref_due <= 1'b1;
    end else begin
      ref_tmr <= ref_tmr + 24'd1;
      if (state == ST_REF && tmr == 24'd0) begin
        ref_due <= 1'b0;
      end
    end
  end

  //==========================================================
  // main sequencer
  always @(posedge mclk_in) begin
    if (srst_in) begin
      state <= ST_PAUSE;
      tmr <= 24'h00_0000;
      ref_row <= 7'h00;
      init_cnt <= 4'h0;
      op_write <= 1'b0;
      op_rmw <= 1'b0;
      op_addr <= 16'h0000;
      op_data <= 1'b0;
      req_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= 1'b0;
      init_done_out <= 1'b0;
      ras_n_out <= 1'b1;
      cas_n_out <= 1'b1;
      we_n_out <= 1'b1;
      mux_addr_out <= 8'h00;
      din_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      req_ready_out <= 1'b0;
      if (tmr != 24'd0) begin
        tmr <= tmr - 24'd1;
      end
      case (state)
        ST_PAUSE: begin
          if (tmr == 24'd0) begin
            tmr <= PAUSE_CYCLES;
            state <= ST_PRE;
          end
        end
        ST_IDLE: begin
          if (ref_pending) begin
            // row-only refresh, column strobe stays high
            // no refresh-request pin is driven, so self and pulse refresh never start
            mux_addr_out <= {1'b0, ref_row};
            ras_n_out <= 1'b0;
            tmr <= T_RAS;
            state <= ST_REF;
          end else if (req_valid_in) begin
            op_write <= req_write_in | req_rmw_in;
            op_rmw <= req_rmw_in;
            op_addr <= req_addr_in;
            // device stores complement where row bit 0 equals column bit 1
            op_data <= req_data_in ^ ~(req_addr_in[8] ^ req_addr_in[1]);
            mux_addr_out <= req_addr_in[15:8];
            state <= ST_ROW;
          end else begin
            req_ready_out <= 1'b1;
          end
        end
        ST_ROW: begin
          ras_n_out <= 1'b0;
          tmr <= T_RCD;
          state <= ST_COL;
        end
        ST_COL: begin
          if (tmr <= T_RCD - T_RAH) begin
            mux_addr_out <= op_addr[7:0];
          end
          if (tmr == 24'd0) begin
            din_out <= op_data;
            // early write: write line low on the same clock edge as the column fall
            we_n_out <= ~(op_write & ~op_rmw);
            cas_n_out <= 1'b0;
            tmr <= T_ACC;
            state <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (tmr == 24'd0) begin
            if (!op_write || op_rmw) begin
              // output only trusted for reads and read-write cycles
              rd_valid_out <= 1'b1;
              // taken before the column strobe rises and the output floats
              rd_data_out <= dout_sync ^ ~(op_addr[8] ^ op_addr[1]);
            end
            if (op_rmw) begin
              // delayed write: data captured at the write fall
              we_n_out <= 1'b0;
              tmr <= T_WP;
              state <= ST_WR;
            end else begin
              state <= ST_END;
            end
          end
        end
        ST_WR: begin
          if (tmr == 24'd0) begin
            state <= ST_END;
          end
        end
        ST_END: begin
          // strobes rise first; write line released after them
          ras_n_out <= 1'b1;
          cas_n_out <= 1'b1;
          tmr <= T_PRE;
          state <= ST_PRE;
        end
        ST_PRE: begin
          we_n_out <= 1'b1;
          if (tmr == 24'd0) begin
            if (init_cnt == INIT_N) begin
              init_done_out <= 1'b1;
            end
            state <= ST_IDLE;
          end
        end
        ST_REF: begin
          if (tmr == 24'd0) begin
            ras_n_out <= 1'b1;
            ref_row <= ref_row + 7'd1;
            if (init_cnt != INIT_N) begin
              init_cnt <= init_cnt + 4'd1;
            end
            tmr <= T_PRE;
            state <= ST_PRE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // dmc_ctrl
`default_nettype wire

// >>> verification/dmc_ctrl_chk.sv
// pin checker for the dram controller
`timescale 1ns/100ps
`default_nettype none
module dmc_ctrl_chk #(
  parameter [23:0] PAUSE_CYCLES = 24'h00_0004,
  parameter [23:0] REF_CYCLES = 24'h00_003c
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // watched outputs
  input wire logic init_done_out,
  input wire logic ras_n_out,
  input wire logic cas_n_out,
  input wire logic we_n_out,
  input wire logic [7:0] mux_addr_out,
  input wire logic din_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  logic [15:0] hi;
  logic [15:0] gap;
  logic [3:0] nras;
  logic [7:0] lrow;
  logic rq;
  wire fall = rq && !ras_n_out;
  // precharge timer, refresh gap, row strobe count
  always @(posedge mclk_in) begin
    rq <= ras_n_out;
    hi <= (srst_in || !ras_n_out) ? 16'h0000 : hi + 16'h0001;
    gap <= (srst_in || fall) ? 16'h0000 : gap + 16'h0001;
    nras <= srst_in ? 4'h0 : nras + {3'h0, fall && nras != 4'hf};
    if (fall) lrow <= mux_addr_out;
  end
  // ====================
  // checks
  AST_CAS_LEAD: assert property ($fell(cas_n_out) |-> !$past(ras_n_out, 4)) else $error("column lead short");
  AST_INIT_CAS: assert property (!init_done_out |-> cas_n_out) else $error("column strobe in init");
  AST_WE_REL: assert property ($rose(we_n_out) |-> ras_n_out && cas_n_out) else $error("write released early");
  AST_EARLY_D: assert property ($fell(cas_n_out) && !we_n_out |=> $stable(din_out)[*3]) else $error("data moved");
  AST_LATE_D: assert property ($fell(we_n_out) && !cas_n_out |=> $stable(din_out)[*3]) else $error("data moved");
  AST_PRECHG: assert property ($fell(ras_n_out) |-> hi >= 16'h000e) else $error("precharge short");
  AST_REF_GAP: assert property (init_done_out |-> gap <= REF_CYCLES + 24'h00_0046) else $error("refresh late");
  AST_INIT_N: assert property ($rose(init_done_out) |-> nras == 4'h8) else $error("init strobe count");
  AST_ROW_STEP: assert property ($fell(ras_n_out) && !init_done_out && nras != 4'h0 |->
    mux_addr_out[6:0] == lrow[6:0] + 7'h01 && !mux_addr_out[7]) else $error("refresh row skip");
  cover property ($fell(cas_n_out) && !we_n_out);
  cover property ($fell(we_n_out) && !cas_n_out);
  cover property ($rose(init_done_out));
endmodule // dmc_ctrl_chk
bind dmc_ctrl dmc_ctrl_chk #(.PAUSE_CYCLES(PAUSE_CYCLES), .REF_CYCLES(REF_CYCLES)) u_chk (.*);
`default_nettype wire

// >>> verification/dmc_ram_mdl.sv
// behavioural model of the 64k x 1 dram
`timescale 1ns/100ps
`default_nettype none
module dmc_ram_mdl (
  // strobes, address, data in
  input wire logic ras_n_in,
  input wire logic cas_n_in,
  input wire logic we_n_in,
  input wire logic [7:0] addr_in,
  input wire logic din_in,
  // data out
  output logic dout_out
);
  logic mem [0:65535]; // one bit per word
  logic [7:0] row;
  logic [15:0] a;
  logic early = 1'h0;
  logic drv = 1'h0;
  logic q = 1'h0;
  logic col_on = 1'h0;
  // row half latched; row-only cycle touches nothing else
  always @(negedge ras_n_in) row = addr_in;
  // column fall: latch, early write stored inverted on pattern
  always @(negedge cas_n_in) if (!ras_n_in) begin
    col_on = 1'h1;
    a = {row, addr_in};
    early = !we_n_in;
    drv = 1'h0;
    if (early) mem[a] = din_in ^ (a[8] == a[1]);
    #110;
    // read data one column access time later
    if (!cas_n_in && !early) begin
      q = mem[a] ^ (a[8] == a[1]);
      drv = 1'h1;
    end
  end
  // late write fall stores the bit; only once the column is latched
  always @(negedge we_n_in) if (col_on && !early) mem[a] = din_in ^ (a[8] == a[1]);
  // output stays put while column low, released shows the inverse
  always @(posedge cas_n_in) begin
    drv = 1'h0;
    col_on = 1'h0;
  end
  assign dout_out = drv ? q : ~q;
endmodule // dmc_ram_mdl
`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the dram controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic mclk_in = 1'h0;
  logic srst_in = 1'h1;
  logic req_valid_in = 1'h0;
  logic req_write_in = 1'h0;
  logic req_rmw_in = 1'h0;
  logic req_data_in = 1'h0;
  logic [15:0] req_addr_in = 16'h0000;
  logic [7:0] mux_addr_out;
  logic req_ready_out, rd_valid_out, rd_data_out, init_done_out, ras_n_out, cas_n_out, we_n_out, din_out, dout_in;
  logic q;
  int n_mismatch = 0;
  int n_tests = 0;
  dmc_ctrl #(.PAUSE_CYCLES(24'h00_0014), .REF_CYCLES(24'h00_003c)) DUT (.mclk_in(mclk_in), .srst_in(srst_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_rmw_in(req_rmw_in), .req_addr_in(req_addr_in),
    .req_data_in(req_data_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .init_done_out(init_done_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .we_n_out(we_n_out),
    .mux_addr_out(mux_addr_out), .din_out(din_out), .dout_in(dout_in));
  dmc_ram_mdl mdl (.ras_n_in(ras_n_out), .cas_n_in(cas_n_out), .we_n_in(we_n_out), .addr_in(mux_addr_out),
    .din_in(din_out), .dout_out(dout_in));
  // 100 MHz clock
  initial forever #5 mclk_in = ~mclk_in;
  task automatic stop_test;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  // one access; valid held until the column strobe falls
  task automatic acc(input logic w, input logic m, input logic [15:0] a, input logic d, output logic r);
    int i = 0;
    while (req_ready_out !== 1'h1 && i < 400) begin @(negedge mclk_in); i++; end
    req_valid_in = 1'h1;
    req_write_in = w;
    req_rmw_in = m;
    req_addr_in = a;
    req_data_in = d;
    while (cas_n_out !== 1'h0 && i < 400) begin @(negedge mclk_in); i++; end
    req_valid_in = 1'h0;
    while (!w && rd_valid_out !== 1'h1 && i < 400) begin @(negedge mclk_in); i++; end
    r = rd_data_out;
    if (i >= 400) begin
      n_mismatch++;
      $display("BAD wait exp 400 got %0d", i);
      stop_test;
    end
  endtask
  task automatic t_map;
    logic [15:0] a;
    for (int k = 0; k < 8; k++) begin
      a = 16'h4020 | {7'h00, k[0], 6'h00, k[1], 1'h0};
      acc(1'h1, 1'h0, a, k[2], q);
      acc(1'h0, 1'h0, a, 1'h0, q);
      chk("cell", k[2], mdl.mem[a]);
      chk("read", k[2], q);
    end
    $display("map test done");
  endtask
  task automatic t_rmw;
    acc(1'h1, 1'h0, 16'h1302, 1'h1, q);
    acc(1'h0, 1'h1, 16'h1302, 1'h0, q);
    chk("rmw old", 1'h1, q);
    acc(1'h0, 1'h0, 16'h1302, 1'h0, q);
    chk("rmw new", 1'h0, q);
    $display("rmw test done");
  endtask
  task automatic t_back;
    for (int k = 0; k < 6; k++) acc(1'h1, 1'h0, 16'h9000 + 16'(k) * 16'h0101, k[0], q);
    for (int k = 0; k < 6; k++) begin
      acc(1'h0, 1'h0, 16'h9000 + 16'(k) * 16'h0101, 1'h0, q);
      chk("back", k[0], q);
    end
    $display("back-to-back test done");
  endtask
  // reset, init wait, then the scenarios
  initial begin
    int i = 0;
    repeat (12) @(negedge mclk_in);
    srst_in = 1'h0;
    while (init_done_out !== 1'h1 && i < 2000) begin @(negedge mclk_in); i++; end
    chk("init", 1'h1, init_done_out);
    if (init_done_out !== 1'h1) begin
      stop_test;
    end
    t_map;
    t_rmw;
    t_back;
    stop_test;
  end
endmodule // tb
`default_nettype wire
